// [rtl/nv_data_store_unlock_ctrl.sv]
// apb slave: key unlock, program/erase sequencer and 256-word data store
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module nv_data_store_unlock_ctrl
    import nv_store_pkg::*;
#(
    parameter int depth = 256,
    parameter int op_cycles = cycle_count
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    localparam int aw = $clog2(depth);

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [15:0] mem [depth];
    unlock_t unlock, next_unlock;
    logic busy, next_busy;
    logic error_flag, next_error_flag;
    logic [op_width-1:0] op_sel, next_op_sel;
    logic [aw-1:0] target, next_target;
    logic [15:0] wr_data, next_wr_data;
    logic [7:0] vis_page, next_vis_page;
    logic [15:0] vis_ea, next_vis_ea;
    logic [31:0] timer, next_timer;
    logic [1:0] irq_stat, next_irq_stat;
    logic [1:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic access, wr, rd, done;
    logic [23:0] vis_addr;
    logic [15:0] ctrl_view;

    assign access = psel && penable && !pready;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign done = busy && (timer == 32'h0000_0001);
    assign ctrl_view = {busy, 1'b0, error_flag, 6'h00, op_sel};
    // page fills bits 22:15, so its bit 0 lands on address bit 15; ea bit 15 dropped
    assign vis_addr = {1'b0, vis_page, vis_ea[14:0]};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_unlock = unlock;
        next_busy = busy;
        next_error_flag = error_flag;
        next_op_sel = op_sel;
        next_target = target;
        next_wr_data = wr_data;
        next_vis_page = vis_page;
        next_vis_ea = vis_ea;
        next_timer = timer;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        next_prdata = 32'h0000_0000;
        next_pready = access;
        next_pslverr = 1'b0;
        // window lasts one access only, whatever it is
        if (unlock == unlock_open && access) begin
            next_unlock = unlock_idle;
        end else if (unlock == unlock_first && access) begin
            if (wr && paddr == key_off && pwdata[7:0] == key_second) begin
                next_unlock = unlock_open;
            end else begin
                next_unlock = unlock_idle;
            end
        end else if (wr && paddr == key_off && pwdata[7:0] == key_first) begin
            next_unlock = unlock_first;
        end
        if (wr && paddr == ctrl_off) begin
            if (unlock == unlock_open && !busy) begin
                next_op_sel = pwdata[op_lsb +: op_width];
                if (pwdata[busy_bit]) begin
                    next_busy = 1'b1;
                    next_error_flag = 1'b0;
                    next_timer = 32'(op_cycles);
                end
            end
        end else if (wr && paddr == addr_off) begin
            next_target = pwdata[aw-1:0];
        end else if (wr && paddr == data_off) begin
            next_wr_data = pwdata[15:0];
        end else if (wr && paddr == vis_off) begin
            next_vis_page = pwdata[23:16];
            next_vis_ea = pwdata[15:0];
        end else if (wr && paddr == irq_mask_off) begin
            next_irq_mask = pwdata[1:0];
        end else if (wr && paddr != key_off) begin
            next_pslverr = 1'b1;
        end
        if (rd) begin
            if (paddr == ctrl_off) begin
                next_prdata = {16'h0000, ctrl_view};
            end else if (paddr == addr_off) begin
                // shown as the full program-space word address of the target
                next_prdata = {8'h00, store_base + 24'(target)};
            end else if (paddr == data_off) begin
                next_prdata = {16'h0000, mem[target]};
            end else if (paddr == vis_off) begin
                next_prdata = {8'h00, vis_page, vis_ea};
            end else if (paddr == vis_addr_off) begin
                next_prdata = {8'h00, vis_addr};
            end else if (paddr == irq_stat_off) begin
                next_prdata = {30'h0, irq_stat};
            end else if (paddr == irq_mask_off) begin
                next_prdata = {30'h0, irq_mask};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // read clears, but a completion in the same cycle still lands
        if (rd && paddr == irq_stat_off) begin
            next_irq_stat = 2'b00;
        end
        if (busy) begin
            next_timer = timer - 32'h0000_0001;
        end
        if (done) begin
            next_busy = 1'b0;
            next_irq_stat[0] = 1'b1;
            if (op_sel != op_word_write && op_sel != op_word_erase && op_sel != op_all_erase) begin
                next_error_flag = 1'b1;
                next_irq_stat[1] = 1'b1;
            end
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock <= unlock_idle;
            busy <= 1'b0;
            error_flag <= 1'b0;
            op_sel <= '0;
            target <= '0;
            wr_data <= 16'h0000;
            vis_page <= page_program;
            vis_ea <= 16'h0000;
            timer <= 32'h0000_0000;
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            unlock <= next_unlock;
            busy <= next_busy;
            error_flag <= next_error_flag;
            op_sel <= next_op_sel;
            target <= next_target;
            wr_data <= next_wr_data;
            vis_page <= next_vis_page;
            vis_ea <= next_vis_ea;
            timer <= next_timer;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    // array has no reset; contents are nonvolatile in intent
    // one process per word, so no word has two drivers
    for (genvar i = 0; i < depth; i++) begin : g_word
        always_ff @(posedge pclk) begin
            if (done && !next_error_flag) begin
                if (op_sel == op_all_erase || (op_sel == op_word_erase && target == aw'(i))) begin
                    mem[i] <= 16'hffff;
                end else if (op_sel == op_word_write && target == aw'(i)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    end
endmodule

// [rtl/nv_store_pkg.sv]
// constants and types for the nonvolatile data store unlock controller
// Operation
// - store words are sixteen bits wide, each word individually addressable
// - store holds 256 sixteen-bit words
// - store sits at top of program space from word address 7FFE00h
// - core keeps executing while a program or erase cycle runs
// - key register is write-only, guards against accidental program or erase
// - after unlock, control register accepts a write for exactly one cycle; the code keeps the window open for the next APB access instead
// - go bit written inside the window starts the selected cycle
// - control upper byte holds start bits and error flag
// - control lower byte selects the operation kind
// - bit 15 stays set while the cycle runs, clears at completion
// - visibility page select: 00 program memory, FF data store
// - program address bit 15 comes from visibility page bit 0
// - top bit of data effective address ignored for visibility address
package nv_store_pkg;
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] key_off = 12'h004;
    localparam logic [11:0] addr_off = 12'h008;
    localparam logic [11:0] vis_off = 12'h00c;
    localparam logic [11:0] data_off = 12'h010;
    localparam logic [11:0] irq_stat_off = 12'h014;
    localparam logic [11:0] irq_mask_off = 12'h018;
    localparam logic [11:0] vis_addr_off = 12'h01c;
    localparam logic [7:0] key_first = 8'h55;
    localparam logic [7:0] key_second = 8'haa;
    localparam logic [7:0] page_program = 8'h00;
    localparam logic [7:0] page_store = 8'hff;
    localparam logic [23:0] store_base = 24'h7ffe00;
    localparam int busy_bit = 15;
    localparam int error_bit = 13;
    localparam int op_lsb = 0;
    localparam int op_width = 7;
    // op code values in the lower byte
    localparam logic [6:0] op_word_write = 7'h04;
    localparam logic [6:0] op_word_erase = 7'h58;
    localparam logic [6:0] op_all_erase = 7'h50;
    localparam int cycle_time_ns = 4000000;
    localparam int clk_period_ns = 50;
    localparam int cycle_count = cycle_time_ns / clk_period_ns;
    typedef enum logic [1:0] {
        unlock_idle = 2'b00,
        unlock_first = 2'b01,
        unlock_open = 2'b11
    } unlock_t;
endpackage

// [tb/nv_store_sva.sv]
// concurrent assertions on the apb port of the nv store controller
`timescale 1ns/1ns
module nv_store_sva
    import nv_store_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    logic take;
    assign take = psel && penable && !pready;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    answer_late_a: assert property (take |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
    idle_ready_a: assert property (!psel |=> !pready) else $error("stray ready");
    err_alone_a: assert property (pslverr |-> pready) else $error("stray error");
    key_read_a: assert property (take && !pwrite && paddr == key_off |=> pslverr) else $error("key read");
    ctrl_write_a: assert property (take && pwrite && paddr == ctrl_off |=> !pslverr) else $error("ctrl err");
    ctrl_poll_a: assert property (take && !pwrite && paddr == ctrl_off |=> !pslverr) else $error("poll err");
    vis_top_a: assert property (take && paddr == vis_addr_off |=> prdata[31:23] == 9'h000) else $error("vis top");
endmodule

// [tb/tb.sv]
// self-checking bench for the nv store unlock controller
`timescale 1ns/1ns
module tb;
    import nv_store_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, s;
    int n_fail, num_checks;
    logic [6:0] ops [4] = '{op_word_write, op_word_erase, op_all_erase, 7'h7f};
    logic [7:0] pgs [2] = '{page_program, page_store};
    nv_data_store_unlock_ctrl #(.op_cycles(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic start(input logic [6:0] op);
        apb(1, key_off, {24'h0, key_first});
        apb(1, key_off, {24'h0, key_second});
        apb(1, ctrl_off, {16'h0, 1'b1, 8'h00, op});
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // cut a hang short well past the expected few hundred cycles
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        s = 32'h08ff;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ctrl_off, 0);
        chk(r, 0);
        apb(0, key_off, 0);
        chk({31'h0, e}, 1);
        apb(0, 12'h020, 0);
        chk({31'h0, e}, 1);
        apb(1, irq_mask_off, 1);
        // no unlock, unlock broken by a read, read inside the open window
        for (int k = 0; k < 3; k++) begin
            if (k > 0) apb(1, key_off, {24'h0, key_first});
            if (k == 1) apb(0, addr_off, 0);
            if (k > 0) apb(1, key_off, {24'h0, key_second});
            if (k == 2) apb(0, addr_off, 0);
            apb(1, ctrl_off, 32'h8004);
            apb(0, ctrl_off, 0);
            chk({31'h0, r[15]}, 0);
        end
        foreach (ops[i]) begin
            s = lfsr(s);
            apb(1, addr_off, {24'h0, s[7:0]});
            apb(0, addr_off, 0);
            chk(r, {8'h0, store_base + {16'h0, s[7:0]}});
            apb(1, data_off, {16'h0, s[31:16]});
            start(ops[i]);
            apb(0, ctrl_off, 0);
            chk({31'h0, r[15]}, 1);
            for (int t = 0; t < 40 && r[15] !== 1'b0; t++) apb(0, ctrl_off, 0);
            chk({30'h0, r[15], r[13]}, {31'h0, i == 3});
            if (i == 1 || i == 2) begin
                apb(0, data_off, 0);
                chk(r, 32'h0000ffff);
            end
            if (i == 0) begin
                apb(0, data_off, 0);
                chk(r, {16'h0, s[31:16]});
                chk({31'h0, irq}, 1);
                apb(0, irq_stat_off, 0);
                chk({31'h0, r[0]}, 1);
                repeat (3) @(posedge pclk);
                chk({31'h0, irq}, 0);
                apb(1, irq_mask_off, 0);
            end
        end
        chk({31'h0, irq}, 0);
        // ea bit 15 is set but must not reach the built address
        foreach (pgs[j]) begin
            s = lfsr(s);
            apb(1, vis_off, {8'h0, pgs[j], 1'b1, s[14:0]});
            apb(0, vis_addr_off, 0);
            chk(r, {9'h0, pgs[j], s[14:0]});
        end
        wrap_up();
    end
endmodule
bind nv_data_store_unlock_ctrl nv_store_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq);
